/* hdl/dspcd_cfg.svh */
`ifndef DSPCD_CFG_SVH
`define DSPCD_CFG_SVH
`define DSPCD_WORD_W        16
`define DSPCD_ACC_W         32
`define DSPCD_PC_W          12
`define DSPCD_STACK_DEPTH   4
`define DSPCD_RAM_WORDS     144
`define DSPCD_RAM_AW        8
`define DSPCD_PAGE_WORDS    128
`define DSPCD_PAGE_AW       7
`define DSPCD_AUX_CNT_W     9
`define DSPCD_ROM_WORDS     1536
`define DSPCD_PROG_WORDS    4096
`define DSPCD_CYCLE_NS      200
`define DSPCD_CLK_NS        10
`define DSPCD_CYCLE_CLKS    (`DSPCD_CYCLE_NS / `DSPCD_CLK_NS)
`define DSPCD_ACC_MAX       32'h7fffffff
`define DSPCD_ACC_MIN       32'h80000000
`define DSPCD_PC_RST        12'h000
`define DSPCD_ACC_RST       32'h00000000
`define DSPCD_AUX_RST       16'h0000
`define DSPCD_SH_ZERO       2'h0
`define DSPCD_SH_ONE        2'h1
`define DSPCD_SH_FOUR       2'h2
`endif

/* hdl/dspcd_pkg.sv */
package dspcd_pkg;
   typedef enum logic [4:0] {
      OP_NOP    = 5'h00,
      OP_LOAD   = 5'h01,
      OP_ADD    = 5'h02,
      OP_SUB    = 5'h03,
      OP_AND    = 5'h04,
      OP_OR     = 5'h05,
      OP_XOR    = 5'h06,
      OP_LOADT  = 5'h07,
      OP_MPY    = 5'h08,
      OP_PAC    = 5'h09,
      OP_APAC   = 5'h0a,
      OP_SPAC   = 5'h0b,
      OP_STLO   = 5'h0c,
      OP_STHI   = 5'h0d,
      OP_LDAUX  = 5'h0e,
      OP_SELAUX = 5'h0f,
      OP_LDPAGE = 5'h10,
      OP_SETSAT = 5'h11,
      OP_CLRSAT = 5'h12,
      OP_BOV    = 5'h13,
      OP_BR     = 5'h14,
      OP_CALL   = 5'h15,
      OP_RET    = 5'h16,
      OP_PIN    = 5'h17,
      OP_POUT   = 5'h18,
      OP_TABLE_READ_OP   = 5'h19,
      OP_TABLE_WRITE_OP   = 5'h1a,
      OP_WRSTAT = 5'h1b,
      OP_SETMSK = 5'h1c,
      OP_CLRMSK = 5'h1d
   } dspcd_op_t;

   typedef enum logic [1:0] {
      ST_FETCH = 2'b00,
      ST_EXEC  = 2'b01,
      ST_IRQ   = 2'b10
   } dspcd_state_t;

   typedef struct packed {
      dspcd_op_t   op;
      logic        indirect;
      logic [6:0]  addr;
      logic [3:0]  shift;
      logic [1:0]  storeShift;
      logic [1:0]  auxStep;
      logic [11:0] target;
      logic [15:0] imm;
   } dspcd_instr_t;

   typedef struct packed {
      logic auxSelect;
      logic pageSelect;
      logic irqPending;
      logic irqMask;
      logic overflow;
      logic saturate;
   } dspcd_status_t;
endpackage

/* hdl/dspcd_data_ram.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dspcd_cfg.svh"
module dspcd_data_ram #(
   parameter int WORDS = `DSPCD_RAM_WORDS,
   parameter int AW    = `DSPCD_RAM_AW,
   parameter int DW    = `DSPCD_WORD_W
) (
   input  wire logic          sys_clk,
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [DW-1:0] wrData,
   input  wire logic [AW-1:0] rdAddr,
   output var  logic [DW-1:0] rdData
);
   logic [DW-1:0] mem [WORDS];

   // out-of-range addresses are ignored on write and read as zero
   always_ff @(posedge sys_clk)
   begin
      if (wrEn && (int'(wrAddr) < WORDS))
      begin
         mem[wrAddr] <= wrData;
      end
      rdData <= (int'(rdAddr) < WORDS) ? mem[rdAddr] : '0;
   end
endmodule
`default_nettype wire

/* hdl/dspcd_multiplier.sv */
`timescale 1ns/1ps
`default_nettype none
module dspcd_multiplier #(
   parameter int DW = 16
) (
   input  wire logic [DW-1:0]   multiplicand,
   input  wire logic [DW-1:0]   multiplier,
   output var  logic [2*DW-1:0] product
);
   // full signed product; single cycle, well inside one instruction cycle
   always_comb
   begin
      product = (2*DW)'($signed(multiplicand) * $signed(multiplier));
   end
endmodule
`default_nettype wire

/* hdl/dspcd_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dspcd_cfg.svh"
// What this block does
// - two 16-bit pointers; low nine bits count up/down
// - one select bit picks the current auxiliary pointer
// - page bit gives direct page; 128 words a page
// - pending flag sets on request, holds while pending
// - interrupt mask bit blocks interrupt entry; the pending flag still sets while masked
// - overflow flag sets when accumulator arithmetic overflows
// - saturate mode bit selects saturating or wrapping results
// - saturate loads most positive or negative value by overflow sign
// - overflow flag clears only by branch-on-overflow or status write
// - 12-bit program counter holds the fetch address
// - 4 x 12-bit stack: push on call or interrupt, pop on return
// - 32-bit product register receives every multiply result
// - 16-bit multiplicand register feeds the multiplier
// - signed 16 by 16 multiply finishes within one instruction cycle
// - RAM operands shift left 0 to 15 places
// - accumulator store shifter allows only 0, 1 or 4 places
// - 32-bit ALU; accumulator is destination and primary operand
// - logical ops use data on low half, zero on high half
// - accumulator stored as separate high and low halves
// - operands come only from the 144-word on-chip data RAM
// - port in/out and table read/write move words between spaces
// - program space is 4K words, optional 1536-word ROM plus off-chip
// - prefetch address loads while current instruction decodes
module dspcd_core #(
   parameter int ROM_WORDS = `DSPCD_ROM_WORDS
) (
   input  wire logic                   sys_clk,
   input  wire logic                   nrst,
   input  wire logic [15:0]            progData,
   output var  logic [11:0]            progAddr,
   output var  logic                   progWrEn,
   output var  logic [15:0]            progWrData,
   input  wire dspcd_pkg::dspcd_instr_t instr,
   output var  logic                   instrTake,
   input  wire logic                   irqReq,
   output var  logic                   irqTaken,
   input  wire logic [15:0]            portInData,
   output var  logic                   portRd,
   output var  logic                   portWr,
   output var  logic [15:0]            portOutData,
   output var  logic                   romSel,
   output var  logic                   clockOutput,
   output var  logic [31:0]            accumulatorOut,
   output var  logic [31:0]            productOut,
   output var  dspcd_pkg::dspcd_status_t statusOut,
   output var  logic [15:0]            auxPointerZeroOut,
   output var  logic [15:0]            auxPointerOneOut
);
   typedef logic [11:0] dspcd_pc_t;

   dspcd_pkg::dspcd_state_t  state_q, state_d;
   dspcd_pkg::dspcd_instr_t  cur_q, cur_d;
   dspcd_pkg::dspcd_status_t st_q, st_d;
   logic [31:0]   acc_q, acc_d;
   logic [31:0]   prod_q, prod_d;
   logic [15:0]   mcand_q, mcand_d;
   logic [15:0]   aux_q [2];
   logic [15:0]   aux_d [2];
   dspcd_pc_t     pc_q, pc_d;
   dspcd_pc_t     stack_q [`DSPCD_STACK_DEPTH];
   dspcd_pc_t     stack_d [`DSPCD_STACK_DEPTH];
   logic          clock_output_q, clock_output_d;
   logic [15:0]   portOut_q, portOut_d;
   logic [15:0]   progWr_q, progWr_d;
   logic          ramWe;
   logic [7:0]    ramWAddr;
   logic [7:0]    ramRAddr;
   logic [15:0]   ramWData;
   logic [15:0]   ramRData;
   logic [31:0]   product;
   logic [31:0]   shiftedOp;
   logic [31:0]   storeVal;
   logic [32:0]   sum;
   logic [31:0]   addend;
   logic [15:0]   curAux;
   logic [7:0]    opAddr;

   dspcd_data_ram dspcd_data_ram_inst (
      .sys_clk (sys_clk),
      .wrEn    (ramWe),
      .wrAddr  (ramWAddr),
      .wrData  (ramWData),
      .rdAddr  (ramRAddr),
      .rdData  (ramRData)
   );

   dspcd_multiplier #(.DW(16)) dspcd_multiplier_inst (
      .multiplicand (mcand_q),
      .multiplier   (ramRData),
      .product      (product)
   );

   // operand address: direct uses page bit, indirect uses current pointer
   always_comb
   begin
      curAux = st_q.auxSelect ? aux_q[1] : aux_q[0];
      if (instr.indirect)
      begin
         opAddr = curAux[7:0];
      end
      else
      begin
         opAddr = {st_q.pageSelect, instr.addr};
      end
      // fetch-phase read so the word is ready when execution begins
      ramRAddr = (state_q == dspcd_pkg::ST_FETCH) ? opAddr : ramWAddr;
   end

   // sign-extended arithmetic left shift of the RAM word
   always_comb
   begin
      shiftedOp = 32'($signed({{16{ramRData[15]}}, ramRData}) <<< cur_q.shift);
   end

   // store shifter: only 0, 1 or 4; other codes act as zero
   always_comb
   begin
      case (cur_q.storeShift)
         `DSPCD_SH_ONE:  storeVal = {acc_q[30:0], 1'b0};
         `DSPCD_SH_FOUR: storeVal = {acc_q[27:0], 4'h0};
         default:        storeVal = acc_q;
      endcase
   end

   always_comb
   begin
      case (cur_q.op)
         dspcd_pkg::OP_SUB:  addend = ~shiftedOp;
         dspcd_pkg::OP_APAC: addend = prod_q;
         dspcd_pkg::OP_SPAC: addend = ~prod_q;
         default:            addend = shiftedOp;
      endcase
      sum = {1'b0, acc_q} + {1'b0, addend}
            + 33'((cur_q.op == dspcd_pkg::OP_SUB) || (cur_q.op == dspcd_pkg::OP_SPAC));
   end

   always_comb
   begin
      state_d   = state_q;
      cur_d     = cur_q;
      st_d      = st_q;
      acc_d     = acc_q;
      prod_d    = prod_q;
      mcand_d   = mcand_q;
      aux_d     = aux_q;
      pc_d      = pc_q;
      stack_d   = stack_q;
      clock_output_d  = clock_output_q;
      portOut_d = portOut_q;
      progWr_d  = progWr_q;
      ramWe     = 1'b0;
      ramWAddr  = {st_q.pageSelect, cur_q.addr};
      ramWData  = 16'h0000;
      instrTake = 1'b0;
      irqTaken  = 1'b0;
      portRd    = 1'b0;
      portWr    = 1'b0;
      progWrEn  = 1'b0;
      if (irqReq)
      begin
         st_d.irqPending = 1'b1;
      end
      case (state_q)
         dspcd_pkg::ST_FETCH:
         begin
            // clock output falls: next address loads as current decodes
            clock_output_d  = 1'b0;
            instrTake = 1'b1;
            cur_d     = instr;
            pc_d      = pc_q + 12'h001;
            if (st_q.irqPending && !st_q.irqMask)
            begin
               state_d = dspcd_pkg::ST_IRQ;
            end
            else
            begin
               state_d = dspcd_pkg::ST_EXEC;
            end
         end
         dspcd_pkg::ST_IRQ:
         begin
            irqTaken  = 1'b1;
            // a newer request in this cycle keeps the flag set
            st_d.irqPending = irqReq;
            st_d.irqMask = 1'b1;
            for (int i = `DSPCD_STACK_DEPTH - 1; i > 0; i--)
            begin
               stack_d[i] = stack_q[i-1];
            end
            stack_d[0] = pc_q - 12'h001;
            pc_d    = 12'h002;
            state_d = dspcd_pkg::ST_FETCH;
         end
         dspcd_pkg::ST_EXEC:
         begin
            clock_output_d = 1'b1;
            state_d  = dspcd_pkg::ST_FETCH;
            if (cur_q.indirect)
            begin
               aux_d[st_q.auxSelect][8:0] = aux_q[st_q.auxSelect][8:0] + {{7{cur_q.auxStep[1]}}, cur_q.auxStep};
               ramWAddr = curAux[7:0];
            end
            case (cur_q.op)
               dspcd_pkg::OP_LOAD: acc_d = shiftedOp;
               dspcd_pkg::OP_ADD, dspcd_pkg::OP_SUB, dspcd_pkg::OP_APAC, dspcd_pkg::OP_SPAC:
               begin
                  acc_d = sum[31:0];
                  if ((acc_q[31] == addend[31]) && (sum[31] != acc_q[31]))
                  begin
                     st_d.overflow = 1'b1;
                     if (st_q.saturate)
                     begin
                        acc_d = acc_q[31] ? `DSPCD_ACC_MIN : `DSPCD_ACC_MAX;
                     end
                  end
               end
               dspcd_pkg::OP_AND: acc_d = {16'h0000, acc_q[15:0] & ramRData};
               dspcd_pkg::OP_OR:  acc_d = {acc_q[31:16], acc_q[15:0] | ramRData};
               dspcd_pkg::OP_XOR: acc_d = {acc_q[31:16], acc_q[15:0] ^ ramRData};
               dspcd_pkg::OP_LOADT: mcand_d = ramRData;
               dspcd_pkg::OP_MPY:   prod_d = product;
               dspcd_pkg::OP_PAC:   acc_d = prod_q;
               dspcd_pkg::OP_STLO:
               begin
                  ramWe    = 1'b1;
                  ramWData = acc_q[15:0];
               end
               dspcd_pkg::OP_STHI:
               begin
                  ramWe    = 1'b1;
                  ramWData = storeVal[31:16];
               end
               dspcd_pkg::OP_LDAUX: aux_d[cur_q.imm[0]] = ramRData;
               dspcd_pkg::OP_SELAUX: st_d.auxSelect = cur_q.imm[0];
               dspcd_pkg::OP_LDPAGE: st_d.pageSelect = cur_q.imm[0];
               dspcd_pkg::OP_SETSAT: st_d.saturate = 1'b1;
               dspcd_pkg::OP_CLRSAT: st_d.saturate = 1'b0;
               dspcd_pkg::OP_SETMSK: st_d.irqMask = 1'b1;
               dspcd_pkg::OP_CLRMSK: st_d.irqMask = 1'b0;
               dspcd_pkg::OP_WRSTAT:
               begin
                  st_d.overflow   = ramRData[0];
                  st_d.saturate   = ramRData[1];
                  st_d.auxSelect  = ramRData[2];
                  st_d.pageSelect = ramRData[3];
                  st_d.irqMask    = ramRData[4];
               end
               dspcd_pkg::OP_BOV:
               begin
                  if (st_q.overflow)
                  begin
                     pc_d = cur_q.target;
                     st_d.overflow = 1'b0;
                  end
               end
               dspcd_pkg::OP_BR: pc_d = cur_q.target;
               dspcd_pkg::OP_CALL:
               begin
                  for (int i = `DSPCD_STACK_DEPTH - 1; i > 0; i--)
                  begin
                     stack_d[i] = stack_q[i-1];
                  end
                  stack_d[0] = pc_q;
                  pc_d = cur_q.target;
               end
               dspcd_pkg::OP_RET:
               begin
                  // pop: deepest entry is duplicated, as with a plain shift stack
                  pc_d = stack_q[0];
                  for (int i = 0; i < `DSPCD_STACK_DEPTH - 1; i++)
                  begin
                     stack_d[i] = stack_q[i+1];
                  end
               end
               dspcd_pkg::OP_PIN:
               begin
                  portRd   = 1'b1;
                  ramWe    = 1'b1;
                  ramWData = portInData;
               end
               dspcd_pkg::OP_POUT:
               begin
                  portWr    = 1'b1;
                  portOut_d = ramRData;
               end
               dspcd_pkg::OP_TABLE_READ_OP:
               begin
                  ramWe    = 1'b1;
                  ramWData = progData;
               end
               dspcd_pkg::OP_TABLE_WRITE_OP:
               begin
                  progWrEn = 1'b1;
                  progWr_d = ramRData;
               end
               default: acc_d = acc_q;
            endcase
         end
         default: state_d = dspcd_pkg::ST_FETCH;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q   <= dspcd_pkg::ST_FETCH;
         cur_q     <= '0;
         st_q      <= '0;
         acc_q     <= `DSPCD_ACC_RST;
         prod_q    <= `DSPCD_ACC_RST;
         mcand_q   <= 16'h0000;
         aux_q[0]  <= `DSPCD_AUX_RST;
         aux_q[1]  <= `DSPCD_AUX_RST;
         pc_q      <= `DSPCD_PC_RST;
         for (int i = 0; i < `DSPCD_STACK_DEPTH; i++)
         begin
            stack_q[i] <= `DSPCD_PC_RST;
         end
         clock_output_q  <= 1'b1;
         portOut_q <= 16'h0000;
         progWr_q  <= 16'h0000;
      end
      else
      begin
         state_q   <= state_d;
         cur_q     <= cur_d;
         st_q      <= st_d;
         acc_q     <= acc_d;
         prod_q    <= prod_d;
         mcand_q   <= mcand_d;
         aux_q     <= aux_d;
         pc_q      <= pc_d;
         stack_q   <= stack_d;
         clock_output_q  <= clock_output_d;
         portOut_q <= portOut_d;
         progWr_q  <= progWr_d;
      end
   end

   // table accesses address program space by the accumulator low bits
   always_comb
   begin
      progAddr = ((cur_q.op == dspcd_pkg::OP_TABLE_READ_OP || cur_q.op == dspcd_pkg::OP_TABLE_WRITE_OP)
                  && state_q == dspcd_pkg::ST_EXEC) ? acc_q[11:0] : pc_q;
      romSel   = (int'(progAddr) < ROM_WORDS);
   end

   assign progWrData        = progWr_q;
   assign portOutData       = portOut_q;
   assign clockOutput       = clock_output_q;
   assign accumulatorOut    = acc_q;
   assign productOut        = prod_q;
   assign statusOut         = st_q;
   assign auxPointerZeroOut = aux_q[0];
   assign auxPointerOneOut  = aux_q[1];
endmodule
`default_nettype wire

/* tb/dspcd_core_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dspcd_core_chk #(
   parameter int ROM_WORDS = 1536
) (
   input wire logic                     sys_clk,
   input wire logic                     nrst,
   input wire dspcd_pkg::dspcd_instr_t  instr,
   input wire logic                     instrTake,
   input wire logic                     irqReq,
   input wire logic                     irqTaken,
   input wire logic                     portRd,
   input wire logic                     portWr,
   input wire logic [11:0]              progAddr,
   input wire logic                     progWrEn,
   input wire logic                     romSel,
   input wire logic                     clockOutput,
   input wire logic [31:0]              accumulatorOut,
   input wire logic [31:0]              productOut,
   input wire dspcd_pkg::dspcd_status_t statusOut,
   input wire logic [15:0]              auxPointerZeroOut
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   property p_take_alt; instrTake |=> !instrTake && !clockOutput; endproperty
   a_take_alt: assert property (p_take_alt) else $error("fetch not followed by exec");
   property p_io_exec; portRd || portWr || progWrEn |-> !instrTake; endproperty
   a_io_exec: assert property (p_io_exec) else $error("transfer strobe in fetch cycle");
   property p_rom; romSel == (progAddr < ROM_WORDS); endproperty
   a_rom: assert property (p_rom) else $error("rom select wrong");
   property p_pend_set; irqReq |=> statusOut.irqPending; endproperty
   a_pend_set: assert property (p_pend_set) else $error("pending flag not set");
   property p_pend_hold; statusOut.irqPending && !irqTaken |=> statusOut.irqPending; endproperty
   a_pend_hold: assert property (p_pend_hold) else $error("pending flag lost");
   property p_mask; irqTaken |-> !statusOut.irqMask; endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt taken");
   property p_ov_hold;
      statusOut.overflow && instrTake && !(instr.op inside {dspcd_pkg::OP_BOV, dspcd_pkg::OP_WRSTAT})
         |=> statusOut.overflow [*2];
   endproperty
   a_ov_hold: assert property (p_ov_hold) else $error("overflow flag cleared");
   property p_and_hi; instrTake && instr.op == dspcd_pkg::OP_AND |-> ##2 accumulatorOut[31:16] == 16'h0000; endproperty
   a_and_hi: assert property (p_and_hi) else $error("and left upper half");
   property p_orx_hi;
      instrTake && instr.op inside {dspcd_pkg::OP_OR, dspcd_pkg::OP_XOR}
         |-> ##2 accumulatorOut[31:16] == $past(accumulatorOut[31:16], 2);
   endproperty
   a_orx_hi: assert property (p_orx_hi) else $error("or/xor changed upper half");
   property p_prod; $changed(productOut) |-> $past(instrTake, 2) && $past(instr.op, 2) == dspcd_pkg::OP_MPY; endproperty
   a_prod: assert property (p_prod) else $error("product changed without multiply");
   // upper seven bits are plain storage, only a load may move them
   property p_aux_hi;
      $changed(auxPointerZeroOut[15:9]) |-> $past(instrTake, 2) && $past(instr.op, 2) == dspcd_pkg::OP_LDAUX;
   endproperty
   a_aux_hi: assert property (p_aux_hi) else $error("pointer upper bits counted");
   c_mpy: cover property (instrTake && instr.op == dspcd_pkg::OP_MPY);
   c_irq: cover property (irqTaken);
   c_ov: cover property ($rose(statusOut.overflow));
endmodule
bind dspcd_core dspcd_core_chk #(.ROM_WORDS(ROM_WORDS)) dspcd_core_chk_inst (
   .sys_clk, .nrst, .instr, .instrTake, .irqReq, .irqTaken, .portRd, .portWr, .progAddr, .progWrEn, .romSel,
   .clockOutput, .accumulatorOut, .productOut, .statusOut, .auxPointerZeroOut
);
`default_nettype wire

/* tb/dspcd_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module dspcd_far_side (
   input  wire logic        sys_clk,
   input  wire logic [11:0] progAddr,
   input  wire logic        progWrEn,
   input  wire logic [15:0] progWrData,
   input  wire logic        portRd,
   input  wire logic [15:0] periphWord,
   output var  logic [15:0] progData,
   output var  logic [15:0] portInData
);
   logic [15:0] mem [4096];
   logic [11:0] wrAddr;
   logic        wrPend;
   initial
   begin
      wrPend = 1'b0;
      wrAddr = 12'h000;
      for (int i = 0; i < 4096; i++)
         mem[i] = 16'(i) ^ 16'ha5a5;
   end
   assign progData = mem[progAddr];
   // stale peripheral data is inverted so a late sample cannot pass
   assign portInData = portRd ? periphWord : ~periphWord;
   // write data trails the strobe by a cycle, so the address is held
   always @(posedge sys_clk)
   begin
      if (wrPend)
         mem[wrAddr] <= progWrData;
      wrPend <= progWrEn;
      wrAddr <= progAddr;
   end
endmodule
`default_nettype wire

/* tb/test_dsp_core_arithmetic_datapath.sv */
`timescale 1ns/1ps
`default_nettype none
module test_dsp_core_arithmetic_datapath;
   typedef struct packed {
      dspcd_pkg::dspcd_op_t op;
      logic [6:0]           a;
      logic [3:0]           sh;
      logic [15:0]          imm;
      logic                 ck;
      logic [31:0]          acc;
      logic [1:0]           ov;
   } dspcd_step_t;
   logic                     sys_clk, nrst, irqReq, ind, progWrEn, instrTake, irqTaken;
   logic                     portRd, portWr, romSel, clockOutput;
   logic [15:0]              periphWord, progData, progWrData, portInData, portOutData, aux0, aux1;
   logic [11:0]              takePc, keepPc, progAddr;
   logic [31:0]              accumulatorOut, productOut;
   dspcd_pkg::dspcd_instr_t  instr;
   dspcd_pkg::dspcd_status_t statusOut;
   int                       error_cnt = 0;
   int                       cmp_count = 0;
   int                       irqCnt = 0;
   logic [15:0]              ramInit [12] = '{16'h8ebc, 16'h0ff0, 16'h00ff, 16'h7fff, 16'h8000, 16'hfffe,
                                              16'h0003, 16'h1234, 16'h0000, 16'hfa0b, 16'h0001, 16'hfc00};
   logic [15:0]              hiExp [4] = '{16'h0012, 16'h0024, 16'h0123, 16'h0012};
   dspcd_step_t              steps [24] = '{
      '{dspcd_pkg::OP_LOAD, 1, 8, 0, 1, 32'hff8ebc00, 0}, '{dspcd_pkg::OP_AND, 2, 0, 0, 1, 32'h00000c00, 0},
      '{dspcd_pkg::OP_LOAD, 1, 8, 0, 0, 0, 0}, '{dspcd_pkg::OP_OR, 3, 0, 0, 1, 32'hff8ebcff, 0},
      '{dspcd_pkg::OP_XOR, 3, 0, 0, 1, 32'hff8ebc00, 0}, '{dspcd_pkg::OP_LOAD, 11, 15, 0, 1, 32'h00008000, 0},
      '{dspcd_pkg::OP_LOAD, 4, 15, 0, 0, 0, 0}, '{dspcd_pkg::OP_ADD, 4, 15, 0, 1, 32'h7fff0000, 2},
      '{dspcd_pkg::OP_ADD, 4, 15, 0, 1, 32'hbffe8000, 3}, '{dspcd_pkg::OP_LOAD, 11, 0, 0, 1, 32'h00000001, 3},
      '{dspcd_pkg::OP_BOV, 0, 0, 16'h0040, 0, 0, 2}, '{dspcd_pkg::OP_SETSAT, 0, 0, 0, 0, 0, 0},
      '{dspcd_pkg::OP_LOAD, 4, 15, 0, 0, 0, 0}, '{dspcd_pkg::OP_ADD, 4, 15, 0, 0, 0, 2},
      '{dspcd_pkg::OP_ADD, 4, 15, 0, 1, 32'h7fffffff, 3}, '{dspcd_pkg::OP_LOAD, 5, 15, 0, 1, 32'hc0000000, 3},
      '{dspcd_pkg::OP_SUB, 4, 15, 0, 1, 32'h80008000, 3}, '{dspcd_pkg::OP_SUB, 4, 15, 0, 1, 32'h80000000, 3},
      '{dspcd_pkg::OP_CLRSAT, 0, 0, 0, 0, 0, 0}, '{dspcd_pkg::OP_LOADT, 6, 0, 0, 0, 0, 0},
      '{dspcd_pkg::OP_MPY, 7, 0, 0, 0, 0, 0}, '{dspcd_pkg::OP_PAC, 0, 0, 0, 1, 32'hfffffffa, 0},
      '{dspcd_pkg::OP_APAC, 0, 0, 0, 1, 32'hfffffff4, 0}, '{dspcd_pkg::OP_LOAD, 8, 8, 0, 1, 32'h00123400, 0}};

   dspcd_core dspcd_core_inst (
      .sys_clk, .nrst, .progData, .progAddr, .progWrEn, .progWrData, .instr, .instrTake, .irqReq, .irqTaken,
      .portInData, .portRd, .portWr, .portOutData, .romSel, .clockOutput, .accumulatorOut, .productOut,
      .statusOut, .auxPointerZeroOut(aux0), .auxPointerOneOut(aux1)
   );
   dspcd_far_side dspcd_far_side_inst (
      .sys_clk, .progAddr, .progWrEn, .progWrData, .portRd, .periphWord, .progData, .portInData
   );

   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
      if (irqTaken === 1'b1)
         irqCnt++;

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one instruction: offered until taken, swapped for NOP after its fetch edge, returns just past its exec edge
   task automatic run(input dspcd_pkg::dspcd_op_t op, input logic [6:0] a, input logic [3:0] sh,
                      input logic [15:0] imm);
      int n;
      instr = '{op, ind, a, sh, sh[1:0], sh[1:0], imm[11:0], imm};
      n = 0;
      while (instrTake !== 1'b1 && n < 8)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n == 8)
      begin
         error_cnt++;
         $display("ERROR %0t no fetch slot", $time);
         tally_and_finish();
      end
      takePc = progAddr;
      @(posedge sys_clk);
      #1;
      instr.op = dspcd_pkg::OP_NOP;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic go(input dspcd_pkg::dspcd_op_t op, input logic [6:0] a = 7'd0);
      run(op, a, 4'h0, 16'h0000);
   endtask

   task automatic pin(input logic [6:0] a, input logic [15:0] v);
      periphWord = v;
      go(dspcd_pkg::OP_PIN, a);
   endtask

   initial
   begin
      sys_clk = 1'b0;
      nrst = 1'b0;
      irqReq = 1'b0;
      ind = 1'b0;
      periphWord = 16'h0000;
      instr = '0;
      repeat (4) @(posedge sys_clk);
      #1;
      chk(accumulatorOut | productOut | 32'(statusOut) | 32'(aux0) | 32'(aux1), 32'h00000000);
      chk(32'({clockOutput, progAddr}), 32'h00001000);
      nrst = 1'b1;
      for (int i = 0; i < 12; i++)
         pin(7'(i + 1), ramInit[i]);
      for (int i = 0; i < 24; i++)
      begin
         run(steps[i].op, steps[i].a, steps[i].sh, steps[i].imm);
         if (steps[i].ck)
            chk(accumulatorOut, steps[i].acc);
         if (steps[i].ov[1])
            chk(32'(statusOut.overflow), 32'(steps[i].ov[0]));
      end
      chk(productOut, 32'hfffffffa);
      $display("test alu done");
      for (int k = 0; k < 4; k++)
      begin
         run(dspcd_pkg::OP_STHI, 7'(20 + k), 4'(k), 16'h0000);
         go(dspcd_pkg::OP_POUT, 7'(20 + k));
         chk(32'(portOutData), 32'(hiExp[k]));
      end
      go(dspcd_pkg::OP_STLO, 7'd24);
      go(dspcd_pkg::OP_POUT, 7'd24);
      chk(32'(portOutData), 32'h00003400);
      go(dspcd_pkg::OP_TABLE_READ_OP, 7'd9);
      go(dspcd_pkg::OP_POUT, 7'd9);
      chk(32'(portOutData), 32'h0000a1a5);
      go(dspcd_pkg::OP_TABLE_WRITE_OP, 7'd1);
      go(dspcd_pkg::OP_TABLE_READ_OP, 7'd13);
      go(dspcd_pkg::OP_POUT, 7'd13);
      chk(32'(portOutData), 32'h00008ebc);
      $display("test store done");
      go(dspcd_pkg::OP_LDAUX, 7'd10);
      go(dspcd_pkg::OP_SELAUX);
      ind = 1'b1;
      run(dspcd_pkg::OP_LOAD, 7'd0, 4'h1, 16'h0000);
      chk(accumulatorOut, 32'h00000002);
      chk(32'(aux0), 32'h0000fa0c);
      ind = 1'b0;
      run(dspcd_pkg::OP_LDAUX, 7'd12, 4'h0, 16'h0001);
      run(dspcd_pkg::OP_SELAUX, 7'd0, 4'h0, 16'h0001);
      chk(32'(statusOut.auxSelect), 32'h00000001);
      ind = 1'b1;
      run(dspcd_pkg::OP_LOAD, 7'd0, 4'h3, 16'h0000);
      ind = 1'b0;
      chk({aux1, aux0}, 32'hfdfffa0c);
      $display("test aux done");
      run(dspcd_pkg::OP_LDPAGE, 7'd0, 4'h0, 16'h0001);
      pin(7'd3, 16'h5555);
      go(dspcd_pkg::OP_LOAD, 7'd3);
      chk(accumulatorOut, 32'h00005555);
      go(dspcd_pkg::OP_LDPAGE);
      go(dspcd_pkg::OP_LOAD, 7'd3);
      chk(accumulatorOut, 32'h000000ff);
      run(dspcd_pkg::OP_CALL, 7'd0, 4'h0, 16'h0700);
      keepPc = takePc + 12'h001;
      chk(32'({romSel, progAddr}), 32'h00000700);
      go(dspcd_pkg::OP_RET);
      go(dspcd_pkg::OP_NOP);
      chk(32'(takePc), 32'(keepPc));
      $display("test page and call done");
      go(dspcd_pkg::OP_SETMSK);
      irqReq = 1'b1;
      go(dspcd_pkg::OP_NOP);
      irqReq = 1'b0;
      go(dspcd_pkg::OP_NOP);
      chk(32'({statusOut.irqPending, 4'(irqCnt)}), 32'h00000010);
      go(dspcd_pkg::OP_CLRMSK);
      keepPc = takePc + 12'h001;
      go(dspcd_pkg::OP_NOP);
      chk(32'({statusOut.irqMask, 4'(irqCnt), progAddr}), 32'h00011002);
      go(dspcd_pkg::OP_RET);
      go(dspcd_pkg::OP_NOP);
      chk(32'(takePc), 32'(keepPc));
      $display("test irq done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
